// ### tb/lcd_driver_port_mux_properties.sv
/*
  Checker for the LCD driver and port multiplexer, bound to its top module.
  Assumes one pclk domain with presetn as asynchronous active-low reset.
*/
module lcd_driver_port_mux_checker
  import lcd_port_pkg::*;
(
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  // Pins and drive
  input wire logic [NPIN-1:0] pin_i,
  input wire logic [NPIN-1:0] pin_o,
  input wire logic [NPIN-1:0] pin_oe_n,
  input wire logic [NPULL-1:0] pull_up_o,
  input wire logic [NPULL-1:0] pull_dn_o,
  input wire logic test_pull_dn_o,
  input wire logic [NCOM-1:0] com_lcd_o,
  input wire logic [NSEG-1:0] seg_lcd_o,
  input wire logic [NCOM-1:0][2:0] com_level_o,
  input wire logic [NSEG-1:0][2:0] seg_level_o,
  input wire logic [NCD-1:0] cd_func_o,
  input wire logic backup_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [NPIN-1:0] pin_ff;
  logic [3:0] quiet_ff;
  logic com_sel, com_half, com_third, seg_two, seg_half;
  always_comb begin
    com_sel = 1'b0;
    com_half = 1'b0;
    com_third = 1'b0;
    seg_two = 1'b1;
    seg_half = 1'b0;
    for (int c = 0; c < NCOM; c++) begin
      com_sel |= com_level_o[c] == LV_FULL || com_level_o[c] == LV_GND;
      com_half |= com_level_o[c] == LV_HALF;
      com_third |= com_level_o[c] == LV_THIRD || com_level_o[c] == LV_TWO3;
    end
    for (int s = 0; s < NSEG; s++) begin
      seg_two &= seg_level_o[s] == LV_FULL || seg_level_o[s] == LV_GND;
      seg_half |= seg_level_o[s] == LV_HALF;
    end
  end
  // Cycles since any pin moved; saturates so a spurious wake stays visible.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff <= '0;
      quiet_ff <= 4'h0;
    end else begin
      pin_ff <= pin_i;
      quiet_ff <= (pin_i != pin_ff) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hf};
    end
  end
  a_od_low_only: assert property ((pin_o & OD_MASK) == '0)
    else $error("open-drain pin driven high");
  a_pull_inputs: assert property (((pull_up_o | pull_dn_o) & ~pin_oe_n[PULL_BASE+:NPULL]) == '0 &&
    (pull_up_o & pull_dn_o) == '0) else $error("pull on a driven pin or both pulls on");
  a_lcd_group: assert property (com_lcd_o == {NCOM{seg_lcd_o[0]}} && seg_lcd_o[3:0] == com_lcd_o)
    else $error("commons and first segments not switched together");
  a_cd_lcd_excl: assert property ((cd_func_o[9:3] & seg_lcd_o[15:9]) == '0)
    else $error("pin in both LCD and CD use");
  a_half_levels: assert property (com_half |-> seg_two && !com_third)
    else $error("wrong level set under half bias");
  a_third_levels: assert property (com_third |-> !com_half && !seg_half)
    else $error("half level under third bias");
  a_wake_cause: assert property ($fell(backup_o) |-> quiet_ff <= 4'h8)
    else $error("backup ended without a recent pin change");
  a_release_blank: assert property ($fell(backup_o) && com_lcd_o[0] |-> !com_sel [*4])
    else $error("commons selected before non-select slot");
  a_test_pull_rst: assert property (!test_pull_dn_o)
    else $error("test pin pulled down outside reset");
  a_apb_error: assert property (psel && penable |-> pslverr == (paddr > OFS_BACKUP || paddr[1:0] != 2'h0))
    else $error("bus error flag wrong");
endmodule : lcd_driver_port_mux_checker

bind lcd_driver_port_mux lcd_driver_port_mux_checker u_chk (.pclk, .presetn, .paddr, .psel, .penable,
  .pslverr, .pin_i, .pin_o, .pin_oe_n, .pull_up_o, .pull_dn_o, .test_pull_dn_o, .com_lcd_o, .seg_lcd_o,
  .com_level_o, .seg_level_o, .cd_func_o, .backup_o);

// ### tb/lcd_driver_port_mux_tb_top.sv
/*
  Self-checking bench for the LCD driver and port multiplexer.
  Assumes short slot parameters and the panel model on the level outputs.
*/
module lcd_driver_port_mux_tb_top
  import lcd_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HS = 8;
  localparam int TS = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [NPIN-1:0] pin_i = '0;
  logic [31:0] prdata;
  logic pready, pslverr, test_pull_dn_o, backup_o, test_mode_o;
  logic [NPIN-1:0] pin_o, pin_oe_n;
  logic [NPULL-1:0] pull_up_o, pull_dn_o;
  logic [NCOM-1:0] com_lcd_o;
  logic [NSEG-1:0] seg_lcd_o;
  logic [NCOM-1:0][2:0] com_level_o;
  logic [NSEG-1:0][2:0] seg_level_o;
  logic [NCD-1:0] cd_func_o;
  logic [63:0] lit;
  int frame_cyc;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h26a3f6f7;
  logic [31:0] rd_q[$];

  always #12.5 pclk = ~pclk;
  lcd_driver_port_mux #(.HALF_SLOT(HS), .THIRD_SLOT(TS)) u_dut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .pin_i, .pin_o, .pin_oe_n, .pull_up_o, .pull_dn_o,
    .test_pull_dn_o, .com_lcd_o, .seg_lcd_o, .com_level_o, .seg_level_o, .cd_func_o, .backup_o, .test_mode_o);
  lcd_panel_model u_panel (.pclk, .com_level_o, .seg_level_o, .lit, .frame_cyc);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    n_mismatch += rd_q.size();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // Entered just after a rising edge; leaves one idle edge after each transfer.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_mismatch++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) chk(prdata, rd_q.pop_front());
  end

  initial begin
    logic [31:0] d, o;
    logic [15:0] sg;
    int i;
    tick(8);
    chk(test_pull_dn_o, 1'b1);
    chk({pin_oe_n, com_lcd_o, seg_lcd_o, cd_func_o}, {{NPIN{1'b1}}, 30'h0});
    presetn <= 1'b1;
    tick(5);
    chk(test_mode_o, 1'b0);
    rd(OFS_LCD, {29'h0, LCD_BLANK_RST, 1'b0, LCD_DIS_RST});
    rd(8'h40, 32'h0);
    for (i = 0; i < 3; i++) begin
      d = rnd();
      o = rnd();
      apb(1'b1, OFS_DIR, d);
      apb(1'b1, OFS_DOUT, o);
      tick(1);
      chk(pin_oe_n, 29'(~(d[28:0] & (~OD_MASK | ~o[28:0]))));
      chk(pin_o & d[28:0] & ~OD_MASK, o[28:0] & d[28:0] & ~OD_MASK);
      rd(OFS_DIR, d & 32'h1fff_ffff);
    end
    apb(1'b1, OFS_DIR, 32'h0);
    o = rnd();
    pin_i <= o[28:0];
    tick(5);
    rd(OFS_PIN, {3'h0, pin_i});
    apb(1'b1, OFS_PIN, ~o);
    rd(OFS_PIN, {3'h0, pin_i});
    apb(1'b1, OFS_PULL, 32'h5f);
    tick(1);
    chk({pull_up_o, pull_dn_o}, 8'h5a);
    apb(1'b1, OFS_CD, 32'h3ff);
    tick(1);
    chk(cd_func_o, 10'h3ff);
    apb(1'b1, OFS_LCD, 32'h0a5c_0000);
    sg = 16'ha5cf;
    tick(1);
    chk({com_lcd_o, seg_lcd_o}, {4'hf, sg});
    chk(cd_func_o, 10'h3ff & ~{sg[15:9], 3'h0});
    apb(1'b1, OFS_CD, 32'h0);
    for (i = 0; i < 2; i++) begin
      d = rnd();
      o = rnd();
      apb(1'b1, OFS_DISP0, d);
      apb(1'b1, OFS_DISP1, o);
      apb(1'b1, OFS_LCD, 32'h0fff_0000 | {30'h0, i[0], 1'b0});
      tick(32 * (i ? TS : HS));
      chk(lit, {o, d});
      chk(frame_cyc, 8 * (i ? TS : HS));
      rd(OFS_DISP1, o);
    end
    apb(1'b1, OFS_BACKUP, 32'h1);
    tick(1);
    chk(backup_o, 1'b1);
    rd(OFS_LCD, 32'h0fff_0006);
    pin_i <= pin_i ^ 29'h8;
    tick(20);
    chk(backup_o, 1'b1);
    apb(1'b1, OFS_WAKE, 32'h1);
    pin_i <= pin_i ^ 29'h4;
    for (i = 0; i < 20 && backup_o !== 1'b0; i++) tick(1);
    chk(backup_o, 1'b0);
    tick(2 * TS);
    rd(OFS_LCD, 32'h0fff_0002);
    pin_i <= pin_i & ~29'h100;
    presetn <= 1'b0;
    tick(2);
    chk(test_pull_dn_o, 1'b1);
    chk({com_lcd_o, cd_func_o, backup_o}, 15'h0);
    presetn <= 1'b1;
    tick(5);
    chk(test_mode_o, 1'b0);
    rd(OFS_LCD, {29'h0, LCD_BLANK_RST, 1'b0, LCD_DIS_RST});
    conclude();
  end
endmodule : lcd_driver_port_mux_tb_top

// ### tb/lcd_panel_model.sv
/*
  Behavioural segment panel: which of the 64 segments are lit, and frame period.
  Assumes level codes from the driver, sampled on pclk.
*/
module lcd_panel_model
  import lcd_port_pkg::*;
(
  // Drive levels and observed state
  input wire logic pclk,
  input wire logic [NCOM-1:0][2:0] com_level_o,
  input wire logic [NSEG-1:0][2:0] seg_level_o,
  output logic [63:0] lit,
  output int frame_cyc
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic was_full = 1'b0;
  initial lit = '0;
  initial frame_cyc = 0;
  // Levels in sixths of the supply: only a full swing lights a segment.
  function automatic int sixths(input logic [2:0] c);
    case (c)
      LV_THIRD: return 2;
      LV_HALF: return 3;
      LV_TWO3: return 4;
      LV_FULL: return 6;
      default: return 0;
    endcase
  endfunction : sixths
  always @(posedge pclk) begin
    was_full <= com_level_o[0] == LV_FULL;
    cnt <= (com_level_o[0] == LV_FULL && !was_full) ? 1 : cnt + 1;
    if (com_level_o[0] == LV_FULL && !was_full) frame_cyc <= cnt;
    for (int c = 0; c < NCOM; c++) begin
      if (sixths(com_level_o[c]) % 6 == 0) begin
        for (int s = 0; s < NSEG; s++) begin
          lit[c * NSEG + s] <= (sixths(com_level_o[c]) - sixths(seg_level_o[s])) inside {-6, 6};
        end
      end
    end
  end
endmodule : lcd_panel_model

// ### verilog/lcd_driver_port_mux.sv
/*
  Segment LCD driver sharing its pins with general-purpose ports, with CD
  processor pin hand-over, pulls, open-drain bits and backup wake on pin change.
  Assumes an APB master on pclk, pads outside that resolve pin_o / pin_oe_n and
  pulls, and an analog level stage that turns level codes into bias voltages.
  Pin 8 is the test strap; the board leaves it open or low outside test.
*/
// Implementation choices: the APB register port and the register addresses.
// How it works
// - Each port bit has its own direction bit.
// - Port 6 input pins get pull-up or pull-down as software selects.
// - Enabled input pin change ends the backup state; enable per whole port.
// - Open-drain bits only pull low or release.
// - Ports 2 to 6 can become LCD driver outputs.
// - Four commons and sixteen segments form a 64-segment matrix.
// - LCD enable puts all commons and the first four segments in LCD mode.
// - Segments five to sixteen choose port or segment per pin.
// - Quarter duty, 62.5 Hz frame at half bias, 125 Hz at third bias.
// - Half bias: commons three levels, segments two levels.
// - Third bias: commons and segments four levels.
// - Backup release: non-select waveform, clear blank bit, then drive commons.
// - Test pin pulled down in reset and sampled as test mode.
// - Designated port 1, 5 and 6 pins go to CD processor per pin.
module lcd_driver_port_mux
  import lcd_port_pkg::*;
#(
  parameter int SLOT_W = 20,
  parameter int HALF_SLOT = HALF_SLOT_CYC,
  parameter int THIRD_SLOT = THIRD_SLOT_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Multiplexed pins
  input wire logic [NPIN-1:0] pin_i,
  output logic [NPIN-1:0] pin_o,
  output logic [NPIN-1:0] pin_oe_n,
  output logic [NPULL-1:0] pull_up_o,
  output logic [NPULL-1:0] pull_dn_o,
  output logic test_pull_dn_o,
  // LCD drive
  output logic [NCOM-1:0] com_lcd_o,
  output logic [NSEG-1:0] seg_lcd_o,
  output logic [NCOM-1:0][2:0] com_level_o,
  output logic [NSEG-1:0][2:0] seg_level_o,
  // CD processor hand-over and status
  output logic [NCD-1:0] cd_func_o,
  output logic backup_o,
  output logic test_mode_o
);

  if (SLOT_W < 2 || SLOT_W > 30 || HALF_SLOT < 1 || THIRD_SLOT < 1 ||
      HALF_SLOT >= (1 << SLOT_W) || THIRD_SLOT >= (1 << SLOT_W)) begin : g_bad_param
    $error("slot lengths do not fit the slot counter");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NPIN-1:0] dir;
    logic [NPIN-1:0] dout;
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] stable;
    logic [2*NPULL-1:0] pull;
    logic [NWAKE_GRP-1:0] wake_en;
    logic lcd_dis;
    logic bias3;
    logic blank;
    logic [NSEG-NSEG_FIXED-1:0] seg_sel;
    logic [63:0] disp;
    logic [NCD-1:0] cd_sel;
    bk_t bk;
    logic [SLOT_W-1:0] slot_cnt;
    logic [2:0] slot;
    logic [2:0] init_cnt;
    logic test_mode;
    logic [NPIN-1:0] pin_o;
    logic [NPIN-1:0] pin_oe_n;
    logic [NCOM-1:0][2:0] com_lvl;
    logic [NSEG-1:0][2:0] seg_lvl;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // ----------------------------------------------------------------
  // Pin function decode
  // ----------------------------------------------------------------
  logic [NPIN-1:0] lcd_pin;
  logic [NPIN-1:0] cd_pin_sel;
  logic [NPIN-1:0] port_fn;
  logic [NPIN-1:0] wake_pin;
  logic [NPIN-1:0] changed;

  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    if (i >= COM_BASE && i < COM_BASE + NCOM) begin : g_com
      assign lcd_pin[i] = ~st_ff.lcd_dis;
    end else if (i >= SEG_BASE && i < SEG_BASE + NSEG_FIXED) begin : g_seg_fix
      assign lcd_pin[i] = ~st_ff.lcd_dis;
    end else if (i >= SEG_BASE + NSEG_FIXED && i < SEG_BASE + NSEG) begin : g_seg_sel
      assign lcd_pin[i] = ~st_ff.lcd_dis & st_ff.seg_sel[i-SEG_BASE-NSEG_FIXED];
    end else begin : g_no_lcd
      assign lcd_pin[i] = 1'b0;
    end
    assign wake_pin[i] = WAKE_MASK[i] & st_ff.wake_en[wake_grp(i)];
    // A change counts once the second and third stages agree on a new level.
    assign changed[i] = (st_ff.s2[i] == st_ff.s3[i]) & (st_ff.s3[i] != st_ff.stable[i]);
  end

  always_comb begin
    cd_pin_sel = '0;
    for (int j = 0; j < NCD; j++) begin
      cd_pin_sel[cd_pin(j)] = st_ff.cd_sel[j];
    end
  end

  // LCD use outranks a CD hand-over on the shared port 5 and 6 pins.
  assign port_fn = ~lcd_pin & ~cd_pin_sel;

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  logic wr;
  logic mapped;

  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr inside {OFS_DIR, OFS_DOUT, OFS_PIN, OFS_PULL, OFS_WAKE, OFS_LCD,
                                 OFS_DISP0, OFS_DISP1, OFS_CD, OFS_BACKUP});
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    prdata = '0;
    if (psel && !pwrite) begin
      unique case (paddr)
        OFS_DIR: prdata[NPIN-1:0] = st_ff.dir;
        OFS_DOUT: prdata[NPIN-1:0] = st_ff.dout;
        OFS_PIN: prdata[NPIN-1:0] = st_ff.stable;
        OFS_PULL: prdata[2*NPULL-1:0] = st_ff.pull;
        OFS_WAKE: prdata[NWAKE_GRP-1:0] = st_ff.wake_en;
        OFS_LCD: begin
          prdata[LCD_DIS_BIT] = st_ff.lcd_dis;
          prdata[LCD_BIAS3_BIT] = st_ff.bias3;
          prdata[LCD_BLANK_BIT] = st_ff.blank;
          prdata[LCD_SEGSEL_LSB +: NSEG-NSEG_FIXED] = st_ff.seg_sel;
        end
        OFS_DISP0: prdata = st_ff.disp[31:0];
        OFS_DISP1: prdata = st_ff.disp[63:32];
        OFS_CD: prdata[NCD-1:0] = st_ff.cd_sel;
        OFS_BACKUP: begin
          prdata[BK_SLEEP_BIT] = (st_ff.bk == BK_SLEEP);
          prdata[BK_REL_BIT] = (st_ff.bk == BK_NONSEL);
          prdata[BK_TEST_BIT] = st_ff.test_mode;
        end
        default: prdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic slot_end;
  logic wake;
  logic ph;
  logic [1:0] cur_com;

  // Compare with >= because a switch to third bias may find the count already past the shorter end.
  // An equality test would then miss the end and run on for a whole counter wrap.
  assign slot_end = st_ff.bias3 ? (st_ff.slot_cnt >= SLOT_W'(THIRD_SLOT - 1))
                                : (st_ff.slot_cnt >= SLOT_W'(HALF_SLOT - 1));
  // Only port inputs wake the block; pins in LCD or CD use are ignored.
  assign wake = |(changed & wake_pin & port_fn & ~st_ff.dir);
  assign ph = st_ff.slot[2];
  assign cur_com = st_ff.slot[1:0];

  always_comb begin
    nxt_st = st_ff;
    // Pin input synchroniser and debounced level.
    nxt_st.s1 = pin_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.stable = (st_ff.stable & ~changed) | (st_ff.s3 & changed);

    // Strap capture: the third stage first holds the pin after the third edge, so take it at the fourth.
    // A capture one edge sooner would read the stage's reset value and never see test mode.
    if (st_ff.init_cnt != 3'h4) begin
      nxt_st.init_cnt = st_ff.init_cnt + 3'h1;
      if (st_ff.init_cnt == 3'h3) begin
        nxt_st.test_mode = st_ff.s3[TEST_PIN];
      end
    end

    // Slot timing: four commons, each driven in both polarities per frame.
    if (slot_end) begin
      nxt_st.slot_cnt = '0;
      nxt_st.slot = st_ff.slot + 3'h1;
    end else begin
      nxt_st.slot_cnt = st_ff.slot_cnt + SLOT_W'(1);
    end

    // Backup sequencing.
    unique case (st_ff.bk)
      BK_RUN: begin
        // Entry to sleep comes from a software write, handled with the other writes.
      end
      BK_SLEEP: begin
        if (wake) begin
          nxt_st.bk = BK_NONSEL;
          nxt_st.slot_cnt = '0;
        end
      end
      BK_NONSEL: begin
        // One full slot of non-select drive before the commons return.
        if (slot_end) begin
          nxt_st.blank = 1'b0;
          nxt_st.bk = BK_RUN;
        end
      end
      default: nxt_st.bk = BK_RUN;
    endcase

    // Software writes come last so a set of the blank bit beats the clear.
    if (wr) begin
      unique case (paddr)
        OFS_DIR: nxt_st.dir = pwdata[NPIN-1:0];
        OFS_DOUT: nxt_st.dout = pwdata[NPIN-1:0];
        OFS_PULL: nxt_st.pull = pwdata[2*NPULL-1:0];
        OFS_WAKE: nxt_st.wake_en = pwdata[NWAKE_GRP-1:0];
        OFS_LCD: begin
          nxt_st.lcd_dis = pwdata[LCD_DIS_BIT];
          nxt_st.bias3 = pwdata[LCD_BIAS3_BIT];
          nxt_st.blank = pwdata[LCD_BLANK_BIT] | nxt_st.blank & (st_ff.bk != BK_RUN);
          nxt_st.seg_sel = pwdata[LCD_SEGSEL_LSB +: NSEG-NSEG_FIXED];
        end
        OFS_DISP0: nxt_st.disp[31:0] = pwdata;
        OFS_DISP1: nxt_st.disp[63:32] = pwdata;
        OFS_CD: nxt_st.cd_sel = pwdata[NCD-1:0];
        OFS_BACKUP: begin
          if (pwdata[BK_SLEEP_BIT] && st_ff.bk == BK_RUN) begin
            nxt_st.bk = BK_SLEEP;
            nxt_st.blank = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Port pin drive; open-drain bits never drive high.
    for (int i = 0; i < NPIN; i++) begin
      nxt_st.pin_o[i] = 1'b0;
      nxt_st.pin_oe_n[i] = 1'b1;
      if (port_fn[i] && st_ff.dir[i]) begin
        if (OD_MASK[i]) begin
          nxt_st.pin_oe_n[i] = st_ff.dout[i];
        end else begin
          nxt_st.pin_o[i] = st_ff.dout[i];
          nxt_st.pin_oe_n[i] = 1'b0;
        end
      end
    end

    // Common levels; a blanked display shows only the non-select waveform.
    for (int c = 0; c < NCOM; c++) begin
      if (cur_com == 2'(c) && !st_ff.blank) begin
        nxt_st.com_lvl[c] = ph ? LV_FULL : LV_GND;
      end else if (st_ff.bias3) begin
        nxt_st.com_lvl[c] = ph ? LV_THIRD : LV_TWO3;
      end else begin
        nxt_st.com_lvl[c] = LV_HALF;
      end
    end

    // Segment levels: on drives opposite the selected common.
    for (int k = 0; k < NSEG; k++) begin
      if (st_ff.disp[{cur_com, 4'(k)}] && !st_ff.blank) begin
        nxt_st.seg_lvl[k] = ph ? LV_GND : LV_FULL;
      end else if (st_ff.bias3) begin
        nxt_st.seg_lvl[k] = ph ? LV_TWO3 : LV_THIRD;
      end else begin
        nxt_st.seg_lvl[k] = ph ? LV_FULL : LV_GND;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.lcd_dis <= LCD_DIS_RST;
      st_ff.blank <= LCD_BLANK_RST;
      st_ff.bk <= BK_RUN;
      st_ff.pin_oe_n <= '1;
      st_ff.com_lvl <= '0;
      st_ff.seg_lvl <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [NPULL-1:0] pull_ok;

  always_comb begin
    for (int i = 0; i < NPULL; i++) begin
      // The registered enable is checked too, so a pull never overlaps the last cycle of drive.
      pull_ok[i] = st_ff.pull[i] & port_fn[PULL_BASE+i] & ~st_ff.dir[PULL_BASE+i] & st_ff.pin_oe_n[PULL_BASE+i];
      pull_up_o[i] = pull_ok[i] & st_ff.pull[PULL_UP_LSB+i];
      pull_dn_o[i] = pull_ok[i] & ~st_ff.pull[PULL_UP_LSB+i];
    end
  end

  // The pull-down follows reset directly so it holds while the clock is idle.
  assign test_pull_dn_o = ~presetn;
  assign pin_o = st_ff.pin_o;
  assign pin_oe_n = st_ff.pin_oe_n;
  assign com_lcd_o = lcd_pin[COM_BASE +: NCOM];
  assign seg_lcd_o = lcd_pin[SEG_BASE +: NSEG];
  assign com_level_o = st_ff.com_lvl;
  assign seg_level_o = st_ff.seg_lvl;
  assign cd_func_o = st_ff.cd_sel & ~{lcd_pin[23:17], lcd_pin[2:0]};
  assign backup_o = (st_ff.bk == BK_SLEEP);
  assign test_mode_o = st_ff.test_mode;

endmodule : lcd_driver_port_mux

// ### verilog/lcd_port_pkg.sv
/*
  Constants shared by the segment LCD driver and port multiplexer: pin layout,
  register offsets, field positions, reset values, drive level codes and timing.
  Assumes a single 40 MHz APB clock domain.
*/
package lcd_port_pkg;

  // ----------------------------------------------------------------
  // Clock and frame timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 40_000_000;
  // Frame rates in milli-hertz so that 62.5 Hz stays exact.
  localparam longint FRAME_HALF_MHZ = 62_500;
  localparam longint FRAME_THIRD_MHZ = 125_000;
  // One frame is eight slots: four commons, each in both polarities.
  localparam int SLOTS_PER_FRAME = 8;
  localparam int HALF_SLOT_CYC = int'((CLK_HZ * 1000) / (FRAME_HALF_MHZ * SLOTS_PER_FRAME));
  localparam int THIRD_SLOT_CYC = int'((CLK_HZ * 1000) / (FRAME_THIRD_MHZ * SLOTS_PER_FRAME));

  // ----------------------------------------------------------------
  // Pin layout
  // ----------------------------------------------------------------
  // Pins 0-3 port 1, 4-7 port 2, 8-11 port 3, 12-15 port 4,
  // 16-19 port 5, 20-23 port 6, 24-26 port 7, 27-28 port 8.
  localparam int NPIN = 29;
  localparam int COM_BASE = 4;
  localparam int SEG_BASE = 8;
  localparam int NCOM = 4;
  localparam int NSEG = 16;
  localparam int NSEG_FIXED = 4;
  localparam int PULL_BASE = 20;
  localparam int NPULL = 4;
  localparam int TEST_PIN = 8;
  localparam int NCD = 10;
  localparam logic [NPIN-1:0] OD_MASK = 29'h0700_0000;
  localparam logic [NPIN-1:0] WAKE_MASK = 29'h1ffe_000f;
  localparam int NWAKE_GRP = 5;

  // Wake enable group of a pin: 0 port 1, 1 port 5, 2 port 6, 3 port 7, 4 port 8.
  function automatic int wake_grp(input int pin);
    if (pin < 4) return 0;
    else if (pin < 20) return 1;
    else if (pin < 24) return 2;
    else if (pin < 27) return 3;
    else return 4;
  endfunction : wake_grp

  // Pin handed to the CD processor by select bit j.
  function automatic int cd_pin(input int j);
    return (j < 3) ? j : j + 14;
  endfunction : cd_pin

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DIR = 8'h00;
  localparam logic [7:0] OFS_DOUT = 8'h04;
  localparam logic [7:0] OFS_PIN = 8'h08;
  localparam logic [7:0] OFS_PULL = 8'h0c;
  localparam logic [7:0] OFS_WAKE = 8'h10;
  localparam logic [7:0] OFS_LCD = 8'h14;
  localparam logic [7:0] OFS_DISP0 = 8'h18;
  localparam logic [7:0] OFS_DISP1 = 8'h1c;
  localparam logic [7:0] OFS_CD = 8'h20;
  localparam logic [7:0] OFS_BACKUP = 8'h24;

  localparam int LCD_DIS_BIT = 0;
  localparam int LCD_BIAS3_BIT = 1;
  localparam int LCD_BLANK_BIT = 2;
  localparam int LCD_SEGSEL_LSB = 16;
  localparam int PULL_UP_LSB = 4;
  localparam int BK_SLEEP_BIT = 0;
  localparam int BK_REL_BIT = 1;
  localparam int BK_TEST_BIT = 2;

  localparam logic LCD_DIS_RST = 1'b1;
  localparam logic LCD_BLANK_RST = 1'b1;

  // ----------------------------------------------------------------
  // Drive level codes of common and segment lines
  // ----------------------------------------------------------------
  localparam logic [2:0] LV_GND = 3'h0;
  localparam logic [2:0] LV_THIRD = 3'h1;
  localparam logic [2:0] LV_HALF = 3'h2;
  localparam logic [2:0] LV_TWO3 = 3'h3;
  localparam logic [2:0] LV_FULL = 3'h4;

  // Backup sequencing states, Gray coded along run, sleep, release.
  typedef enum logic [1:0] {
    BK_RUN = 2'h0,
    BK_SLEEP = 2'h1,
    BK_NONSEL = 2'h3
  } bk_t;

endpackage : lcd_port_pkg
